// ===== rtl/sas_pkg.sv
// Purpose: shared constants for the converter sequencer
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   control/status layout keeps the printed bit order
package sas_pkg;

  // ********************************
  // register offsets
  // ********************************
  localparam logic [11:0] SAS_OFF_CTRL_STATUS = 12'h03C;
  localparam logic [11:0] SAS_OFF_RESULT      = 12'h040;
  localparam logic [11:0] SAS_OFF_CLK_DIV     = 12'h044;
  localparam logic [11:0] SAS_OFF_IRQ_STATUS  = 12'h048;
  localparam logic [11:0] SAS_OFF_IRQ_MASK    = 12'h04C;
  localparam logic [11:0] SAS_OFF_PORT_DATA   = 12'h050;
  localparam logic [11:0] SAS_OFF_PORT_DIR    = 12'h054;
  localparam logic [11:0] SAS_OFF_PORT_PINS   = 12'h058;

  // ********************************
  // field positions
  // ********************************
  localparam int SAS_CS_DONE_BIT  = 7;
  localparam int SAS_CS_IRQEN_BIT = 6;
  localparam int SAS_CS_CONT_BIT  = 5;
  localparam int SAS_CS_SEL_MSB   = 4;
  localparam int SAS_DIV_LSB      = 5;
  localparam int SAS_IRQ_CONV_BIT = 0;
  localparam int SAS_IRQ_ABRT_BIT = 1;

  // ********************************
  // reset values and codes
  // ********************************
  localparam logic [4:0] SAS_SEL_OFF        = 5'h1F;
  localparam logic [2:0] SAS_DIV_RESET      = 3'h0;
  localparam logic [1:0] SAS_IRQ_MASK_RESET = 2'h1;
  localparam logic [7:0] SAS_RESULT_RESET   = 8'h00;
  localparam int         SAS_NUM_CHAN       = 4;
  localparam int         SAS_RES_BITS       = 8;

  // ********************************
  // timing
  // ********************************
  localparam int SAS_CONV_TICKS   = 16;
  localparam int SAS_SAMPLE_TICKS = SAS_CONV_TICKS - SAS_RES_BITS;

  typedef enum logic {SAS_ENG_IDLE, SAS_ENG_CONV} sas_eng_e;

endpackage

// ===== rtl/sas_conv_if.sv
// Purpose: links the register side to the conversion engine
// Assumes: single pclk domain
// Notes:   start is a one-cycle pulse; abort stays high for as long as stop_mode is high
interface sas_conv_if;
  logic [2:0] div_sel;
  logic       start;
  logic       abort;
  logic       busy;
  logic       done;
  logic [7:0] result;

  modport ctrl   (output div_sel, output start, output abort,
                  input busy, input done, input result);
  modport engine (input div_sel, input start, input abort,
                  output busy, output done, output result);
endinterface

// ===== rtl/sas_engine.sv
// Purpose: converter clock divider and successive approximation engine
// Assumes: comparator answers within one pclk of a trial code change
// Notes:   start waits for the next converter clock edge
module sas_engine (
  input  wire logic     pclk,
  input  wire logic     presetn,
  sas_conv_if.engine    cif,
  input  wire logic     above_trial,
  output logic [7:0]    trial_code
);
  import sas_pkg::*;

  // ********************************
  // converter clock enable
  // ********************************
  logic [3:0] div_cnt_q;
  logic [3:0] div_last;
  logic       tick;

  always_comb begin
    unique case (cif.div_sel)
      3'h0:    div_last = 4'h0;
      3'h1:    div_last = 4'h1;
      3'h2:    div_last = 4'h3;
      3'h3:    div_last = 4'h7;
      default: div_last = 4'hF;
    endcase
  end

  assign tick = (div_cnt_q >= div_last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 4'h0;
    end else if (tick) begin
      div_cnt_q <= 4'h0;
    end else begin
      div_cnt_q <= div_cnt_q + 4'h1;
    end
  end

  // ********************************
  // approximation sequence
  // ********************************
  sas_eng_e   state_q;
  logic [3:0] step_q;
  logic [7:0] sar_q;
  logic       pend_q;
  logic [2:0] bit_idx;
  logic [7:0] sar_next;

  assign bit_idx = 3'(4'hF - step_q);

  always_comb begin
    sar_next = sar_q;
    if (!above_trial) begin
      sar_next[bit_idx] = 1'b0;
    end
    if (bit_idx != 3'h0) begin
      sar_next[bit_idx - 3'h1] = 1'b1;
    end
  end

  // start request held until the next converter edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
    end else if (cif.abort) begin
      pend_q <= 1'b0;
    end else if (cif.start) begin
      pend_q <= 1'b1;
    end else if (tick) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SAS_ENG_IDLE;
      step_q  <= 4'h0;
      sar_q   <= 8'h80;
    end else if (cif.abort) begin
      state_q <= SAS_ENG_IDLE;
      step_q  <= 4'h0;
    end else if (tick && pend_q) begin
      state_q <= SAS_ENG_CONV;
      step_q  <= 4'h0;
      sar_q   <= 8'h80;
    end else if (tick && state_q == SAS_ENG_CONV) begin
      step_q <= step_q + 4'h1;
      if (step_q >= 4'(SAS_SAMPLE_TICKS)) begin
        sar_q <= sar_next;
      end
      if (step_q == 4'(SAS_CONV_TICKS - 1)) begin
        state_q <= SAS_ENG_IDLE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cif.done   <= 1'b0;
      cif.result <= SAS_RESULT_RESET;
    end else begin
      cif.done <= 1'b0;
      if (!cif.abort && !(tick && pend_q) && tick && state_q == SAS_ENG_CONV &&
          step_q == 4'(SAS_CONV_TICKS - 1)) begin
        cif.done   <= 1'b1;
        cif.result <= sar_next;
      end
    end
  end

  assign cif.busy   = (state_q == SAS_ENG_CONV) || pend_q;
  assign trial_code = sar_q;

endmodule // sas_engine

// ===== rtl/sas_sequencer.sv
// Purpose: register file, pin sharing, modes and interrupt of the converter
// Assumes: apb slave with zero wait states; comparator outside
// Notes:   engine instance holds divider and approximation steps
module sas_sequencer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  input  wire logic        above_trial,
  output logic      [7:0]  trial_code,
  output logic      [1:0]  mux_channel,
  output logic             mux_enable,
  output logic             converter_powered,
  input  wire logic [3:0]  shared_pin_in,
  output logic      [3:0]  shared_pin_out,
  output logic      [3:0]  shared_pin_oe,
  output logic             irq,
  output logic             wake_request
);
  import sas_pkg::*;

  // ********************************
  // bus decode
  // ********************************
  logic setup_rd;
  logic acc;
  logic acc_wr;
  logic acc_rd;
  logic mapped;

  assign setup_rd = psel && !penable && !pwrite;
  assign acc      = psel && penable;
  assign acc_wr   = acc && pwrite && !pslverr;
  assign acc_rd   = acc && !pwrite && !pslverr;
  assign pready   = 1'b1;

  always_comb begin
    unique case (paddr)
      SAS_OFF_CTRL_STATUS, SAS_OFF_RESULT, SAS_OFF_CLK_DIV,
      SAS_OFF_IRQ_STATUS, SAS_OFF_IRQ_MASK, SAS_OFF_PORT_DATA,
      SAS_OFF_PORT_DIR, SAS_OFF_PORT_PINS: mapped = 1'b1;
      default:                             mapped = 1'b0;
    endcase
  end

  // unmapped or misaligned addresses answer with an error, no side effect
  assign pslverr = acc && !mapped;

  logic wr_cs;
  logic wr_div;
  logic wr_mask;
  logic wr_data;
  logic wr_dir;
  logic rd_result;
  logic rd_irq;

  assign wr_cs     = acc_wr && paddr == SAS_OFF_CTRL_STATUS;
  assign wr_div    = acc_wr && paddr == SAS_OFF_CLK_DIV;
  assign wr_mask   = acc_wr && paddr == SAS_OFF_IRQ_MASK;
  assign wr_data   = acc_wr && paddr == SAS_OFF_PORT_DATA;
  assign wr_dir    = acc_wr && paddr == SAS_OFF_PORT_DIR;
  assign rd_result = acc_rd && paddr == SAS_OFF_RESULT;
  assign rd_irq    = acc_rd && paddr == SAS_OFF_IRQ_STATUS;

  // ********************************
  // control fields
  // ********************************
  logic       irq_en_q;
  logic       cont_q;
  logic [4:0] input_select_q;
  logic [2:0] clock_divide_select_q;
  logic [1:0] irq_mask_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q       <= 1'b0;
      cont_q         <= 1'b0;
      input_select_q <= SAS_SEL_OFF;
    end else if (wr_cs) begin
      // done bit position is write-ignored
      irq_en_q       <= pwdata[SAS_CS_IRQEN_BIT];
      cont_q         <= pwdata[SAS_CS_CONT_BIT];
      input_select_q <= pwdata[SAS_CS_SEL_MSB:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_divide_select_q <= SAS_DIV_RESET;
    end else if (wr_div) begin
      clock_divide_select_q <= pwdata[SAS_DIV_LSB+2:SAS_DIV_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= SAS_IRQ_MASK_RESET;
    end else if (wr_mask) begin
      irq_mask_q <= pwdata[1:0];
    end
  end

  // ********************************
  // power and channel routing
  // ********************************
  logic powered;
  logic external_sel;

  assign powered           = (input_select_q != SAS_SEL_OFF);
  assign external_sel      = (input_select_q < 5'(SAS_NUM_CHAN));
  assign converter_powered = powered && !stop_mode;
  assign mux_enable        = converter_powered && external_sel;
  assign mux_channel       = input_select_q[1:0];

  // ********************************
  // conversion sequencing
  // ********************************
  sas_conv_if cif ();

  logic stop_q;
  logic resume_q;
  logic stop_entry;
  logic stop_exit;
  logic wr_on;

  // judge power from the code being written, not the old one, so a write wakes it
  assign wr_on = (pwdata[SAS_CS_SEL_MSB:0] != SAS_SEL_OFF);

  assign stop_entry = stop_mode && !stop_q;
  assign stop_exit  = !stop_mode && stop_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= stop_mode;
    end
  end

  // remember whether work was cut short so it picks up after stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_q <= 1'b0;
    end else if (stop_entry) begin
      resume_q <= cif.busy || cont_q;
    end else if (wr_cs && stop_mode) begin
      resume_q <= 1'b1;
    end else if (stop_exit) begin
      resume_q <= 1'b0;
    end
  end

  // wait mode is not an input here: the converter runs on regardless
  always_comb begin
    cif.div_sel = clock_divide_select_q;
    cif.abort   = stop_entry || (wr_cs && (!wr_on || stop_mode)) ||
                  (!powered && cif.busy) || stop_mode;
    cif.start   = !stop_mode &&
                  ((wr_cs && wr_on) || (powered && ((stop_exit && resume_q) ||
                   (cif.done && cont_q))));
  end

  sas_engine u_engine (
    .pclk        (pclk),
    .presetn     (presetn),
    .cif         (cif.engine),
    .above_trial (above_trial),
    .trial_code  (trial_code)
  );

  // ********************************
  // result and completion flags
  // ********************************
  logic [7:0] result_q;
  logic       done_flag_q;
  logic       conv_irq_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= SAS_RESULT_RESET;
    end else if (cif.done) begin
      result_q <= cif.result;
    end
  end

  // set wins over a same-cycle result read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag_q <= 1'b0;
    end else if (cif.done && !irq_en_q) begin
      done_flag_q <= 1'b1;
    end else if (rd_result) begin
      done_flag_q <= 1'b0;
    end
  end

  // ********************************
  // interrupt status
  // ********************************
  logic [1:0] irq_set;
  logic [1:0] irq_status_q;

  assign irq_set[SAS_IRQ_CONV_BIT] = cif.done && irq_en_q;
  assign irq_set[SAS_IRQ_ABRT_BIT] = stop_entry && cif.busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_irq_q <= 1'b0;
    end else if (irq_set[SAS_IRQ_CONV_BIT]) begin
      conv_irq_q <= 1'b1;
    end else if (rd_result || wr_cs || rd_irq) begin
      conv_irq_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q[SAS_IRQ_ABRT_BIT] <= 1'b0;
    end else if (irq_set[SAS_IRQ_ABRT_BIT]) begin
      irq_status_q[SAS_IRQ_ABRT_BIT] <= 1'b1;
    end else if (rd_irq) begin
      irq_status_q[SAS_IRQ_ABRT_BIT] <= 1'b0;
    end
  end

  assign irq_status_q[SAS_IRQ_CONV_BIT] = conv_irq_q;

  assign irq          = |(irq_status_q & irq_mask_q);
  assign wake_request = wait_mode && irq;

  // ********************************
  // shared port pins
  // ********************************
  logic [3:0] port_data_q;
  logic [3:0] port_dir_q;
  logic [3:0] pin_read;
  logic [3:0] pin_taken;

  // latches still load; only the pin ignores them while selected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data_q <= 4'h0;
    end else if (wr_data) begin
      port_data_q <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_dir_q <= 4'h0;
    end else if (wr_dir) begin
      port_dir_q <= pwdata[3:0];
    end
  end

  for (genvar p = 0; p < SAS_NUM_CHAN; p++) begin : g_pin
    assign pin_taken[p]      = powered && external_sel &&
                               input_select_q[1:0] == 2'(p);
    assign shared_pin_oe[p]  = port_dir_q[p] && !pin_taken[p];
    assign shared_pin_out[p] = port_data_q[p];
    assign pin_read[p]       = pin_taken[p] ? (port_dir_q[p] && port_data_q[p])
                             : (port_dir_q[p] ? port_data_q[p] : shared_pin_in[p]);
  end

  // ********************************
  // read data
  // ********************************
  logic [7:0] cs_read;

  always_comb begin
    cs_read                   = {3'h0, input_select_q};
    cs_read[SAS_CS_DONE_BIT]  = done_flag_q && !irq_en_q;
    cs_read[SAS_CS_IRQEN_BIT] = irq_en_q;
    cs_read[SAS_CS_CONT_BIT]  = cont_q;
  end

  // captured in the setup phase so the bus sees a registered value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_rd) begin
      unique case (paddr)
        SAS_OFF_CTRL_STATUS: prdata <= {24'h000000, cs_read};
        SAS_OFF_RESULT:      prdata <= {24'h000000, result_q};
        SAS_OFF_CLK_DIV:     prdata <= {24'h000000, clock_divide_select_q, 5'h00};
        SAS_OFF_IRQ_STATUS:  prdata <= {30'h00000000, irq_status_q};
        SAS_OFF_IRQ_MASK:    prdata <= {30'h00000000, irq_mask_q};
        SAS_OFF_PORT_DATA:   prdata <= {28'h0000000, port_data_q};
        SAS_OFF_PORT_DIR:    prdata <= {28'h0000000, port_dir_q};
        SAS_OFF_PORT_PINS:   prdata <= {28'h0000000, pin_read};
        default:             prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // sas_sequencer

// ===== tb/sas_chk.sv
// Purpose: port checks for the converter sequencer
// Assumes: one pclk domain, async active-low reset
// Notes:   bound from the bench top
module sas_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        wait_mode,
  input wire logic        stop_mode,
  input wire logic [1:0]  mux_channel,
  input wire logic        mux_enable,
  input wire logic        converter_powered,
  input wire logic [3:0]  shared_pin_oe,
  input wire logic        irq,
  input wire logic        wake_request
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_stop_powers_down: assert property (
    stop_mode |-> !converter_powered && !mux_enable) else $error("powered in stop");
  a_mux_needs_power: assert property (
    mux_enable |-> converter_powered) else $error("mux on while off");
  a_selected_pin_free: assert property (
    mux_enable |-> !shared_pin_oe[mux_channel]) else $error("selected pin driven");
  a_wake_from_irq: assert property (
    wake_request == (wait_mode && irq)) else $error("wake mismatch");
  a_zero_wait_ready: assert property (
    psel && penable |-> pready) else $error("pready low");
  a_slverr_in_access: assert property (
    pslverr |-> psel && penable) else $error("pslverr outside access");
  a_upper_bits_zero: assert property (
    psel && penable && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_unmapped_reads_zero: assert property (
    pslverr && !pwrite |-> prdata == 32'h0) else $error("unmapped read data");
  c_irq: cover property ($rose(irq));
  c_wake: cover property (wake_request);
  c_slverr: cover property (pslverr);
  c_stop: cover property ($rose(stop_mode));
endmodule // sas_chk

// ===== tb/sas_analog_model.sv
// Purpose: comparator, channel levels and pin wiring outside the block
// Assumes: levels are ideal codes, one per channel
// Notes:   comparator toggles when no channel is routed
module sas_analog_model (
  input wire logic        pclk,
  input wire logic [31:0] levels,
  input wire logic [7:0]  trial_code,
  input wire logic [1:0]  mux_channel,
  input wire logic        mux_enable,
  input wire logic [3:0]  ext_pins,
  input wire logic [3:0]  shared_pin_out,
  input wire logic [3:0]  shared_pin_oe,
  output logic            above_trial,
  output logic [3:0]      shared_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // analog side
  // ****************
  logic [7:0] lvl;
  logic       toggle_q = 1'b0;
  always @(posedge pclk) toggle_q <= ~toggle_q;
  assign lvl = levels[8*mux_channel +: 8];
  // linear ideal transfer; no stale level when unrouted
  assign above_trial = mux_enable ? (lvl >= trial_code) : toggle_q;
  assign shared_pin_in = (shared_pin_oe & shared_pin_out) | (~shared_pin_oe & ext_pins);
endmodule // sas_analog_model

// ===== tb/sar_adc_sequencer_tb.sv
// Purpose: self-checking bench of the converter sequencer
// Assumes: zero-wait apb slave, 25 MHz pclk
// Notes:   timing windows allow for the free-running divider phase
module sar_adc_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sas_pkg::*;
  // ****************
  // signals and parts
  // ****************
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, levels = 32'h0, prdata, q;
  logic        wait_mode = 1'b0, stop_mode = 1'b0, pready, pslverr, above_trial, err;
  logic [7:0]  trial_code;
  logic [1:0]  mux_channel;
  logic        mux_enable, converter_powered, irq, wake_request;
  logic [3:0]  ext_pins = 4'h0, pin_in, pin_out, pin_oe;
  int          bad_count = 0, checked = 0;
  always #20 pclk = ~pclk;
  sas_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .above_trial(above_trial), .trial_code(trial_code), .mux_channel(mux_channel),
    .mux_enable(mux_enable), .converter_powered(converter_powered),
    .shared_pin_in(pin_in), .shared_pin_out(pin_out), .shared_pin_oe(pin_oe),
    .irq(irq), .wake_request(wake_request));
  sas_analog_model u_far (.pclk(pclk), .levels(levels), .trial_code(trial_code),
    .mux_channel(mux_channel), .mux_enable(mux_enable), .ext_pins(ext_pins),
    .shared_pin_out(pin_out), .shared_pin_oe(pin_oe), .above_trial(above_trial),
    .shared_pin_in(pin_in));
  // ****************
  // bus and check tasks
  // ****************
  task automatic print_verdict;
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(negedge pclk);
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic wait_flag;
    int n;
    n = 0;
    do begin
      apb(1'b0, SAS_OFF_CTRL_STATUS, 32'h0);
      n++;
    end while (q[SAS_CS_DONE_BIT] !== 1'b1 && n < 200);
    if (n >= 200) begin
      bad_count++;
      print_verdict();
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    rdchk("ctrl reset", SAS_OFF_CTRL_STATUS, 32'h1F);
    rdchk("div reset", SAS_OFF_CLK_DIV, 32'h0);
    rdchk("mask reset", SAS_OFF_IRQ_MASK, 32'h1);
    chk("powered reset", 32'h0, {31'h0, converter_powered});
  endtask
  task automatic t_conv(input logic [1:0] ch, input logic [7:0] lv);
    levels[8*ch +: 8] <= lv;
    wr(SAS_OFF_CTRL_STATUS, {30'h0, ch});
    chk("mux chan", {30'h0, ch}, {30'h0, mux_channel});
    chk("mux en", 32'h1, {31'h0, mux_enable});
    wait_flag();
    rdchk("result", SAS_OFF_RESULT, {24'h0, lv});
    rdchk("flag clear", SAS_OFF_CTRL_STATUS, {30'h0, ch});
  endtask
  task automatic t_timing;
    int n;
    int r;
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    foreach (codes[i]) begin
      r = codes[i][2] ? 16 : (1 << codes[i][1:0]);
      wr(SAS_OFF_CLK_DIV, {24'h0, codes[i], 5'h0});
      wr(SAS_OFF_CTRL_STATUS, 32'h40);
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while (irq !== 1'b1 && n < 400);
      checked++;
      if (n < 16 * r || n > 17 * r + 4) begin
        $display("[ERR] conversion time expected %0d seen %0d", 16 * r, n);
        bad_count++;
      end
      rdchk("flag irq mode", SAS_OFF_CTRL_STATUS, 32'h40);
      wait_mode <= 1'b1;
      @(negedge pclk);
      chk("wake", 32'h1, {31'h0, wake_request});
      rdchk("irq result", SAS_OFF_RESULT, 32'h0);
      wait_mode <= 1'b0;
      @(negedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
    wr(SAS_OFF_CLK_DIV, 32'h0);
  endtask
  task automatic t_cont;
    levels[23:16] <= 8'h33;
    wr(SAS_OFF_CTRL_STATUS, 32'h22);
    wait_flag();
    levels[23:16] <= 8'hCC;
    repeat (60) @(posedge pclk);
    rdchk("cont result", SAS_OFF_RESULT, 32'hCC);
    wr(SAS_OFF_CTRL_STATUS, 32'h02);
    apb(1'b0, SAS_OFF_RESULT, 32'h0);
    wait_flag();
    rdchk("single result", SAS_OFF_RESULT, 32'hCC);
    repeat (60) @(posedge pclk);
    rdchk("single only", SAS_OFF_CTRL_STATUS, 32'h02);
  endtask
  task automatic t_pins;
    wr(SAS_OFF_PORT_DIR, 32'hF);
    wr(SAS_OFF_PORT_DATA, 32'hA);
    wr(SAS_OFF_CTRL_STATUS, 32'h01);
    chk("oe selected", 32'hD, {28'h0, pin_oe});
    chk("pin out", 32'hA, {28'h0, pin_out});
    rdchk("pins dir1", SAS_OFF_PORT_PINS, 32'hA);
    ext_pins <= 4'hF;
    wr(SAS_OFF_PORT_DIR, 32'h0);
    rdchk("pins dir0", SAS_OFF_PORT_PINS, 32'hD);
    wr(SAS_OFF_CTRL_STATUS, 32'h1F);
    chk("powered off", 32'h0, {31'h0, converter_powered});
    repeat (60) @(posedge pclk);
    apb(1'b0, SAS_OFF_RESULT, 32'h0);
    repeat (60) @(posedge pclk);
    rdchk("off no conv", SAS_OFF_CTRL_STATUS, 32'h1F);
  endtask
  task automatic t_stop;
    wr(SAS_OFF_IRQ_MASK, 32'h3);
    wr(SAS_OFF_CTRL_STATUS, 32'h00);
    repeat (3) @(posedge pclk);
    stop_mode <= 1'b1;
    @(negedge pclk);
    chk("stop powered", 32'h0, {31'h0, converter_powered});
    @(negedge pclk);
    chk("abort irq", 32'h1, {31'h0, irq});
    rdchk("abort status", SAS_OFF_IRQ_STATUS, 32'h2);
    stop_mode <= 1'b0;
    @(negedge pclk);
    chk("status cleared", 32'h0, {31'h0, irq});
    wait_flag();
    apb(1'b0, SAS_OFF_RESULT, 32'h0);
    wr(SAS_OFF_IRQ_MASK, 32'h1);
  endtask
  task automatic t_unmapped;
    apb(1'b0, 12'h0FC, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, q);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_conv(2'h0, 8'h00);
    t_conv(2'h1, 8'hFF);
    t_conv(2'h2, 8'h5A);
    t_conv(2'h3, 8'hA5);
    t_timing();
    t_cont();
    t_pins();
    t_stop();
    t_unmapped();
    print_verdict();
  end
endmodule // sar_adc_sequencer_tb
bind sas_sequencer sas_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .wait_mode(wait_mode), .stop_mode(stop_mode),
  .mux_channel(mux_channel), .mux_enable(mux_enable),
  .converter_powered(converter_powered), .shared_pin_oe(shared_pin_oe), .irq(irq),
  .wake_request(wake_request));
